// >>> sim/ast_afe_model.sv
// Analog front end model: latches a code at each sample pulse
// Assumes the block reads the code at conversion end
`timescale 1ns/1ps
`default_nettype none
module ast_afe_model #(
  parameter RES_W = 10
) (
  input  wire logic             ref_clk,
  input  wire logic             afeSample,
  input  wire logic [RES_W-1:0] nextVal,
  output var  logic [RES_W-1:0] afeData
);
  initial afeData = '0;
  // any code zero to all ones
  always @(posedge ref_clk)
    if (afeSample)
      afeData <= nextVal;
endmodule // ast_afe_model
`default_nettype wire

// >>> sim/ast_sleep_ctrl_checker.sv
// Checker for the converter sleep and sensor control block
// Sees only top ports; bound to ast_sleep_ctrl
`timescale 1ns/1ps
`default_nettype none
module ast_sleep_ctrl_checker #(
  parameter [5:0] SENSOR_CH = 6'h27
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Bus responses
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  // Sleep side
  input wire logic       sleepEnter,
  input wire logic [2:0] sleepMode,
  input wire logic       cpuClkStopped,
  input wire logic       otherWake,
  input wire logic       cpuWake,
  input wire logic       cpuSleeping,
  // Front end
  input wire logic [5:0] afeChannel,
  input wire logic [1:0] afeRef,
  input wire logic       afeEnable,
  input wire logic       afeSample,
  input wire logic       sensorPower
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Sequences
  sequence s_halted;
    cpuSleeping ##0 $rose(cpuClkStopped);
  endsequence
  sequence s_sleep_conv;
    cpuSleeping && afeSample;
  endsequence
  // ==========================================
  // Properties
  a_sensor_off: assert property (!sensorPower || afeChannel == SENSOR_CH || $changed(afeChannel))
    else $error("sensor powered on other channel");
  a_sensor_on: assert property ((afeChannel == SENSOR_CH && afeEnable)[*2] |-> sensorPower)
    else $error("sensor not powered");
  a_sel_frozen: assert property (afeSample |=> ($stable(afeChannel) && $stable(afeRef))[*8])
    else $error("selection moved in conversion");
  a_auto_start: assert property (s_halted |-> ##[0:3] afeSample)
    else $error("no start after clock halt");
  a_sleep_wake: assert property (s_sleep_conv |-> ##[10:20] (cpuWake || !cpuSleeping))
    else $error("no wake after conversion");
  a_early_wake: assert property (cpuSleeping && otherWake |-> ##[1:3] !cpuSleeping)
    else $error("early wake ignored");
  a_stay_active: assert property ($rose(cpuSleeping) |-> $past(sleepEnter) || $past(sleepEnter, 2))
    else $error("sleep without sleep request");
  a_keep_enabled: assert property (sleepEnter && sleepMode > 3'h1 && afeEnable |=> afeEnable[*4])
    else $error("converter disabled by sleep");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule // ast_sleep_ctrl_checker

bind ast_sleep_ctrl ast_sleep_ctrl_checker #(.SENSOR_CH(SENSOR_CH)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .sleepEnter(sleepEnter), .sleepMode(sleepMode), .cpuClkStopped(cpuClkStopped),
  .otherWake(otherWake), .cpuWake(cpuWake), .cpuSleeping(cpuSleeping),
  .afeChannel(afeChannel), .afeRef(afeRef), .afeEnable(afeEnable),
  .afeSample(afeSample), .sensorPower(sensorPower));
`default_nettype wire

// >>> sim/tb_ast_sleep_ctrl.sv
// Testbench for the converter sleep and sensor control block
// Drives AXI4-Lite and sleep inputs; front end is ast_afe_model
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.vh"
module tb_ast_sleep_ctrl;
  localparam [5:0] SCH = 6'h27;
  logic ref_clk = 0, rst_n = 0;
  logic [11:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic sleepEnter = 0, cpuClkStopped = 0, otherWake = 0;
  logic [2:0] sleepMode = 0;
  logic [9:0] nextVal = 0, v;
  logic [5:0] ch;
  wire awReady, wReady, bValid, arReady, rValid, cpuWake, cpuSleeping;
  wire afeEnable, afeSample, sensorPower, irq;
  wire [1:0] bResp, rResp, afeRef;
  wire [31:0] rData;
  wire [5:0] afeChannel;
  wire [9:0] afeData;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  int err_count = 0, check_count = 0;
  always #2 ref_clk = ~ref_clk;
  ast_sleep_ctrl #(.SENSOR_CH(SCH), .RES_W(10)) u_ast_sleep_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sleepEnter(sleepEnter), .sleepMode(sleepMode), .cpuClkStopped(cpuClkStopped),
    .otherWake(otherWake), .cpuWake(cpuWake), .cpuSleeping(cpuSleeping), .afeData(afeData),
    .afeChannel(afeChannel), .afeRef(afeRef), .afeEnable(afeEnable), .afeSample(afeSample),
    .sensorPower(sensorPower), .irq(irq));
  ast_afe_model #(.RES_W(10)) u_ast_afe_model (
    .ref_clk(ref_clk), .afeSample(afeSample), .nextVal(nextVal), .afeData(afeData));
  // ==========================================
  // Tasks
  task automatic chk(string n, logic [33:0] e, logic [33:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r);
    @(posedge ref_clk);
    wq.push_back(r);
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    do
    begin
      @(posedge ref_clk);
      if (awReady) awValid <= 0;
      if (wReady) wValid <= 0;
    end
    while (!(bValid && bReady));
    bReady <= 0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r);
    @(posedge ref_clk);
    rq.push_back({r, d});
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do
    begin
      @(posedge ref_clk);
      if (arReady) arValid <= 0;
    end
    while (!(rValid && rReady));
    rReady <= 0;
  endtask
  task automatic wait_hi(bit wake);
    for (int i = 0; i < 100 && (wake ? cpuWake : irq) !== 1'b1; i++) @(posedge ref_clk);
    chk(wake ? "cpuWake" : "irq", 1, wake ? cpuWake : irq);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // Result monitor
  always @(posedge ref_clk)
  begin
    if (rValid && rReady) chk("rdata", rq.pop_front(), {rResp, rData});
    if (bValid && bReady) chk("bresp", {32'h0, wq.pop_front()}, {32'h0, bResp});
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    logic [9:0] vals[3];
    void'($urandom(93358));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1;
    rd(`AST_OFF_SELECT, 0, `AST_RESP_OKAY);
    rd(`AST_OFF_STATUS, 0, `AST_RESP_OKAY);
    rd(12'h020, 0, `AST_RESP_SLVERR);
    wr(12'h024, 1, `AST_RESP_SLVERR);
    wr(`AST_OFF_MASK, 3, `AST_RESP_OKAY);
    wr(`AST_OFF_CONTROL, 32'h1, `AST_RESP_OKAY);
    ch = 6'($urandom_range(0, 38));
    wr(`AST_OFF_SELECT, {24'h0, 2'h3, ch}, `AST_RESP_OKAY);
    rd(`AST_OFF_SELECT, {24'h0, 2'h3, ch}, `AST_RESP_OKAY);
    chk("sensorPower", 0, sensorPower);
    vals = '{10'h000, `AST_RES_TOP, 10'($urandom)};
    foreach (vals[i])
    begin
      wr(`AST_OFF_SELECT, {24'h0, 2'h3, SCH}, `AST_RESP_OKAY);
      @(posedge ref_clk);
      chk("sensorPower", 1, sensorPower);
      nextVal <= vals[i];
      wr(`AST_OFF_CONTROL, 32'h7, `AST_RESP_OKAY);
      wr(`AST_OFF_SELECT, {24'h0, 2'h1, ch}, `AST_RESP_OKAY);
      chk("afeChannel", SCH, afeChannel);
      wait_hi(0);
      repeat (2) @(posedge ref_clk);
      chk("afeChannel", ch, afeChannel);
      rd(`AST_OFF_RESULT, {22'h0, vals[i]}, `AST_RESP_OKAY);
      wr(`AST_OFF_STATUS, 1, `AST_RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      chk("irq", 0, irq);
    end
    wr(`AST_OFF_MASK, 0, `AST_RESP_OKAY);
    wr(`AST_OFF_SELECT, {24'h0, 2'h3, SCH}, `AST_RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      nextVal <= 10'(k + 5);
      wr(`AST_OFF_CONTROL, 32'h7, `AST_RESP_OKAY);
      repeat (20) @(posedge ref_clk);
    end
    chk("irq", 0, irq);
    rd(`AST_OFF_STATUS, 1, `AST_RESP_OKAY);
    rd(`AST_OFF_RESULT, 32'h6, `AST_RESP_OKAY);
    wr(`AST_OFF_CONTROL, 32'hb, `AST_RESP_OKAY);
    repeat (20) @(posedge ref_clk);
    wr(`AST_OFF_STATUS, 1, `AST_RESP_OKAY);
    repeat (20) @(posedge ref_clk);
    rd(`AST_OFF_STATUS, 1, `AST_RESP_OKAY);
    wr(`AST_OFF_CONTROL, 32'h1, `AST_RESP_OKAY);
    repeat (20) @(posedge ref_clk);
    wr(`AST_OFF_STATUS, 1, `AST_RESP_OKAY);
    repeat (20) @(posedge ref_clk);
    rd(`AST_OFF_STATUS, 0, `AST_RESP_OKAY);
    wr(`AST_OFF_MASK, 3, `AST_RESP_OKAY);
    for (int m = 0; m < 3; m++)
    begin
      v = 10'($urandom);
      wr(`AST_OFF_CONTROL, 32'h5, `AST_RESP_OKAY);
      nextVal <= v;
      sleepEnter <= 1;
      sleepMode <= (m == 0) ? `AST_SLP_IDLE : `AST_SLP_NOISE;
      @(posedge ref_clk);
      sleepEnter <= 0;
      repeat (2) @(posedge ref_clk);
      chk("cpuSleeping", 1, cpuSleeping);
      cpuClkStopped <= 1;
      if (m == 2)
      begin
        repeat (3) @(posedge ref_clk);
        otherWake <= 1;
        @(posedge ref_clk);
        otherWake <= 0;
        repeat (3) @(posedge ref_clk);
        chk("cpuSleeping", 0, cpuSleeping);
        wait_hi(0);
        rd(`AST_OFF_STATUS, 3, `AST_RESP_OKAY);
      end
      else
        wait_hi(1);
      cpuClkStopped <= 0;
      repeat (4) @(posedge ref_clk);
      chk("cpuSleeping", 0, cpuSleeping);
      rd(`AST_OFF_RESULT, {22'h0, v}, `AST_RESP_OKAY);
      wr(`AST_OFF_STATUS, 3, `AST_RESP_OKAY);
    end
    wr(`AST_OFF_CONTROL, 32'h1, `AST_RESP_OKAY);
    sleepEnter <= 1;
    sleepMode <= 3'h2;
    @(posedge ref_clk);
    sleepEnter <= 0;
    repeat (5) @(posedge ref_clk);
    chk("afeEnable", 1, afeEnable);
    chk("cpuSleeping", 0, cpuSleeping);
    wr(`AST_OFF_CONTROL, 0, `AST_RESP_OKAY);
    @(posedge ref_clk);
    chk("afeEnable", 0, afeEnable);
    wr(`AST_OFF_CONTROL, 32'h1, `AST_RESP_OKAY);
    @(posedge ref_clk);
    chk("afeEnable", 1, afeEnable);
    report_and_stop();
  end
endmodule // tb_ast_sleep_ctrl
`default_nettype wire

// >>> src/ast_conv_timer.v
// Conversion sequencer: counts converter cycles and flags the end
// Assumes the analog front end samples at start and delivers data at done
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.vh"
module ast_conv_timer #(
  parameter [7:0] CYCLES = `AST_CONV_CYCLES
) (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst_n,
  // Control
  input  wire start,
  input  wire abort,
  // Status
  output reg  busy,
  output reg  nearEnd,
  output reg  done
);
  reg [7:0] cnt_reg;
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 8'h00;
      busy    <= 1'b0;
      nearEnd <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done    <= 1'b0;
      nearEnd <= 1'b0;
      if (abort)
      begin
        busy    <= 1'b0;
        cnt_reg <= 8'h00;
      end
      else if (start && !busy)
      begin
        busy    <= 1'b1;
        cnt_reg <= CYCLES;
      end
      else if (busy)
      begin
        cnt_reg <= cnt_reg - `AST_ONE;
        if (cnt_reg == (`AST_ONE + `AST_ONE))
          nearEnd <= 1'b1;
        if (cnt_reg == `AST_ONE)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // ast_conv_timer
`default_nettype wire

// >>> src/ast_defines.vh
// Constants for the converter sleep and temperature sensor control block
// Assumes a single 250 MHz clock and 32-bit AXI4-Lite register access
`ifndef AST_DEFINES_VH
`define AST_DEFINES_VH
// ==========================================
// Register byte offsets
`define AST_OFF_SELECT   12'h000
`define AST_OFF_CONTROL  12'h004
`define AST_OFF_RESULT   12'h008
`define AST_OFF_STATUS   12'h00c
`define AST_OFF_MASK     12'h010
`define AST_OFF_STATE    12'h014
// ==========================================
// Select register fields
`define AST_SEL_CH_LSB   0
`define AST_SEL_CH_MSB   5
`define AST_SEL_REF_LSB  6
`define AST_SEL_REF_MSB  7
`define AST_SEL_RESET    8'h00
// ==========================================
// Control register bits
`define AST_CTL_ENABLE   0
`define AST_CTL_START    1
`define AST_CTL_IRQEN    2
`define AST_CTL_FREE     3
// ==========================================
// Status bits
`define AST_ST_DONE      0
`define AST_ST_WAKE      1
// ==========================================
// Sleep mode codes
`define AST_SLP_IDLE     3'h0
`define AST_SLP_NOISE    3'h1
// ==========================================
// Timing, response codes and result range
`define AST_CONV_CYCLES  8'h0d
`define AST_ONE          8'h01
`define AST_RESP_OKAY    2'h0
`define AST_RESP_SLVERR  2'h2
`define AST_RES_TOP      10'h3ff
`endif

// >>> src/ast_result_store.v
// Holds the last conversion result, read data from a register
// Assumes writes only at conversion end
`timescale 1ns/1ps
`default_nettype none
module ast_result_store #(
  parameter WIDTH = 10
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // Write side
  input  wire             wrEn,
  input  wire [WIDTH-1:0] wrData,
  // Read side
  output reg  [WIDTH-1:0] rdData
);
  // ==========================================
  // Storage
  reg [WIDTH-1:0] mem_reg;
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mem_reg <= {WIDTH{1'b0}};
      rdData  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wrEn)
        mem_reg <= wrData;
      rdData <= wrEn ? wrData : mem_reg;
    end
  end
endmodule // ast_result_store
`default_nettype wire

// >>> src/ast_sleep_ctrl.v
// Converter control: temperature sensor select and sleep noise canceler
// Assumes AXI4-Lite master on the register side, analog front end outside
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.vh"
module ast_sleep_ctrl #(
  parameter [5:0] SENSOR_CH = 6'h27,
  parameter       RES_W     = 10
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // AXI4-Lite write address
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // Sleep controller
  input  wire             sleepEnter,
  input  wire [2:0]       sleepMode,
  input  wire             cpuClkStopped,
  input  wire             otherWake,
  output reg              cpuWake,
  output reg              cpuSleeping,
  // Analog front end
  input  wire [RES_W-1:0] afeData,
  output reg  [5:0]       afeChannel,
  output reg  [1:0]       afeRef,
  output reg              afeEnable,
  output reg              afeSample,
  output reg              sensorPower,
  // Interrupt
  output reg              irq
);
  // ==========================================
  // Registers
  reg [7:0]  select_reg;
  reg [3:0]  control_reg;
  reg [1:0]  status_reg;
  reg [1:0]  mask_reg;
  reg [11:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0]  wStrb_reg;
  reg        awHave_reg;
  reg        wHave_reg;
  reg        sleepConv_reg;
  reg        swStart;
  wire       busy;
  wire       nearEnd;
  wire       convDone;
  wire [RES_W-1:0] result;

  // Sleep states
  localparam [2:0] S_RUN   = 3'b001;
  localparam [2:0] S_WAITH = 3'b010;
  localparam [2:0] S_SLEEP = 3'b100;
  reg [2:0] state_reg;

  function isNoiseMode;
    input [2:0] m;
    begin
      isNoiseMode = (m == `AST_SLP_IDLE) || (m == `AST_SLP_NOISE);
    end
  endfunction

  wire wrGo = awHave_reg && wHave_reg && !s_axi_bvalid;
  wire wrSel = wrGo && (awAddr_reg == `AST_OFF_SELECT);
  wire wrCtl = wrGo && (awAddr_reg == `AST_OFF_CONTROL);
  wire wrSts = wrGo && (awAddr_reg == `AST_OFF_STATUS);
  wire wrMsk = wrGo && (awAddr_reg == `AST_OFF_MASK);
  wire enabled = control_reg[`AST_CTL_ENABLE];
  wire autoStart = (state_reg == S_WAITH) && cpuClkStopped && enabled && !busy;
  wire startConv = (swStart || autoStart) && enabled && !busy;

  // ==========================================
  // Conversion timer
  ast_conv_timer #(
    .CYCLES (`AST_CONV_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (startConv),
    .abort   (!enabled),
    .busy    (busy),
    .nearEnd (nearEnd),
    .done    (convDone)
  );

  // ==========================================
  // Result store
  // Full code range kept
  ast_result_store #(
    .WIDTH (RES_W)
  ) u_result (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wrEn    (convDone),
    .wrData  (afeData),
    .rdData  (result)
  );

  // ==========================================
  // Write channel
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 12'h000;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AST_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHave_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHave_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrGo)
      begin
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrSel || wrCtl || wrSts || wrMsk ||
                         awAddr_reg == `AST_OFF_RESULT || awAddr_reg == `AST_OFF_STATE) ?
                        `AST_RESP_OKAY : `AST_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // Control and status registers
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      select_reg  <= `AST_SEL_RESET;
      control_reg <= 4'h0;
      status_reg  <= 2'h0;
      mask_reg    <= 2'h0;
      swStart     <= 1'b0;
    end
    else
    begin
      swStart <= 1'b0;
      if (wrSel && wStrb_reg[0])
        select_reg <= wData_reg[7:0];
      if (wrCtl && wStrb_reg[0])
      begin
        control_reg <= {wData_reg[`AST_CTL_FREE], wData_reg[`AST_CTL_IRQEN],
                        1'b0, wData_reg[`AST_CTL_ENABLE]};
        swStart     <= wData_reg[`AST_CTL_START];
      end
      else if (control_reg[`AST_CTL_FREE] && convDone && enabled)
        swStart <= 1'b1;
      if (wrMsk && wStrb_reg[0])
        mask_reg <= wData_reg[1:0];
      status_reg[`AST_ST_DONE] <= convDone ||
        (status_reg[`AST_ST_DONE] && !(wrSts && wStrb_reg[0] && wData_reg[`AST_ST_DONE]));
      status_reg[`AST_ST_WAKE] <= (convDone && sleepConv_reg && state_reg != S_SLEEP) ||
        (status_reg[`AST_ST_WAKE] && !(wrSts && wStrb_reg[0] && wData_reg[`AST_ST_WAKE]));
    end
  end

  // ==========================================
  // Read channel
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AST_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `AST_RESP_OKAY;
        case ({s_axi_araddr[11:2], 2'h0})
          `AST_OFF_SELECT:  s_axi_rdata <= {24'h000000, select_reg};
          `AST_OFF_CONTROL: s_axi_rdata <= {28'h0000000, control_reg};
          `AST_OFF_RESULT:  s_axi_rdata <= {{(32-RES_W){1'b0}}, result};
          `AST_OFF_STATUS:  s_axi_rdata <= {30'h00000000, status_reg};
          `AST_OFF_MASK:    s_axi_rdata <= {30'h00000000, mask_reg};
          `AST_OFF_STATE:   s_axi_rdata <= {27'h0000000, sensorPower, busy, state_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AST_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Sleep sequencer
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg     <= S_RUN;
      sleepConv_reg <= 1'b0;
      cpuWake       <= 1'b0;
      cpuSleeping   <= 1'b0;
    end
    else
    begin
      cpuWake <= 1'b0;
      if (startConv)
        sleepConv_reg <= autoStart;
      case (state_reg)
        S_RUN:
        begin
          if (sleepEnter && isNoiseMode(sleepMode) && enabled && !busy)
          begin
            state_reg   <= S_WAITH;
            cpuSleeping <= 1'b1;
          end
        end
        S_WAITH:
        begin
          if (otherWake)
          begin
            state_reg   <= S_RUN;
            cpuWake     <= 1'b1;
            cpuSleeping <= 1'b0;
          end
          else if (autoStart)
            state_reg <= S_SLEEP;
        end
        S_SLEEP:
        begin
          if (otherWake || (convDone && control_reg[`AST_CTL_IRQEN]))
          begin
            state_reg   <= S_RUN;
            cpuWake     <= 1'b1;
            cpuSleeping <= 1'b0;
          end
        end
        default:
        begin
          state_reg   <= S_RUN;
          cpuSleeping <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Analog selection and interrupt
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      afeChannel  <= 6'h00;
      afeRef      <= 2'h0;
      afeEnable   <= 1'b0;
      afeSample   <= 1'b0;
      sensorPower <= 1'b0;
      irq         <= 1'b0;
    end
    else
    begin
      if (!busy || nearEnd)
      begin
        afeChannel  <= select_reg[`AST_SEL_CH_MSB:`AST_SEL_CH_LSB];
        afeRef      <= select_reg[`AST_SEL_REF_MSB:`AST_SEL_REF_LSB];
        sensorPower <= enabled &&
                       (select_reg[`AST_SEL_CH_MSB:`AST_SEL_CH_LSB] == SENSOR_CH);
      end
      afeEnable <= enabled;
      afeSample <= startConv;
      irq       <= |(status_reg & mask_reg);
    end
  end
endmodule // ast_sleep_ctrl
`default_nettype wire
